/* File: design/dsoi_consts.vh */
// constants for the ds3 overhead slot insertion port
`ifndef DSOI_CONSTS_VH
`define DSOI_CONSTS_VH
`define DSOI_SLOTS_PER_FRAME 38
`define DSOI_CNT_W 6
`define DSOI_SLOT_P0 6'h10
`define DSOI_SLOT_P1 6'h18
`define DSOI_SLOT_M0 6'h20
`define DSOI_SLOT_SPACING 16'h00AA
`define DSOI_FRAMING_PATTERN 4'h9
`endif

/* File: design/dsoi_port.v */
// ds3 transmit overhead insertion port with strobe and frame mark
`timescale 1ns/100ps
`default_nettype none
`include "dsoi_consts.vh"
// Operation
// - strobe goes high just before each outbound overhead bit is processed.
// - frame mark accompanies the strobe only at count 0, an insertable X bit.
// - odd counts carry F1 F0 F0 F1 framing bits, never insertable.
// - counts 16 and 24 (P) and 32 (M0) refuse insertion.
// - counts 2, 4, 6, 8 accept inserted values.
// - counts 10-14, 18-22, 26-30, 34, 36 accept inserted values.
// - strobe stands exactly one clock period before its overhead bit.
// - requests at non-insertable bits are ignored; the framing bit (odd counts) or internal bit (P, M0) is sent.
// - value sampled on every falling edge, whatever the request level; used only when request is high.
module dsoi_port #(
	parameter SLOTS = `DSOI_SLOTS_PER_FRAME,
	parameter [15:0] SPACING = `DSOI_SLOT_SPACING
) (
	input wire clk_sys,
	input wire rstn,
	input wire ovh_insert_request,
	input wire ovh_insert_value,
	input wire internal_value,
	output reg ovh_slot_strobe,
	output reg ovh_frame_mark,
	output reg ovh_bit_valid,
	output reg ovh_bit_out,
	output reg ovh_bit_inserted,
	output reg [5:0] ovh_slot_index
);
	localparam [31:0] LAST_SLOT = SLOTS - 1;
	// slot divider state
	reg [15:0] gap_q;
	reg [15:0] gap_d;
	reg [5:0] cnt_q;
	reg [5:0] cnt_d;
	// falling-edge capture stage
	reg req_n_q;
	reg val_n_q;
	// three-flop pin filters and their settled levels
	reg [2:0] req_sync_q;
	reg [2:0] val_sync_q;
	reg req_s_q;
	reg req_s_d;
	reg val_s_q;
	reg val_s_d;
	// next values of the registered outputs
	reg strobe_d;
	reg mark_d;
	reg valid_d;
	reg bit_d;
	reg inserted_d;
	reg [5:0] index_d;
	wire insertable;
	wire framing_bit;
	wire fire;
	wire last_slot;
	wire take_request;
	// classifies the slot whose strobe stands now
	dsoi_slot_map dsoi_slot_map_i (
		.slot_cnt(ovh_slot_index),
		.insertable(insertable),
		.framing_bit(framing_bit)
	);
	// falling-edge capture; the terminal moves its pins just after a strobe
	always @(negedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			req_n_q <= 1'b0;
			val_n_q <= 1'b0;
		end else begin
			req_n_q <= ovh_insert_request;
			val_n_q <= ovh_insert_value;
		end
	end
	// stage 0 feeds stage 1 only
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			req_sync_q <= 3'h0;
			val_sync_q <= 3'h0;
		end else begin
			req_sync_q <= {req_sync_q[1:0], req_n_q};
			val_sync_q <= {val_sync_q[1:0], val_n_q};
		end
	end
	// a change counts only once stages 1 and 2 agree
	always @* begin
		req_s_d = req_s_q;
		val_s_d = val_s_q;
		if (req_sync_q[1] == req_sync_q[2]) begin
			req_s_d = req_sync_q[2];
		end
		if (val_sync_q[1] == val_sync_q[2]) begin
			val_s_d = val_sync_q[2];
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			req_s_q <= 1'b0;
		end else begin
			req_s_q <= req_s_d;
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			val_s_q <= 1'b0;
		end else begin
			val_s_q <= val_s_d;
		end
	end
	// slot enable pulses every SPACING+1 clocks; spacing must beat filter latency
	assign fire = (gap_q == 16'h0000);
	assign last_slot = ({26'h0000000, cnt_q} == LAST_SLOT);
	always @* begin
		gap_d = gap_q - 16'h0001;
		cnt_d = cnt_q;
		if (fire) begin
			gap_d = SPACING;
			if (last_slot) begin
				cnt_d = 6'h00;
			end else begin
				cnt_d = cnt_q + 6'h01;
			end
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			gap_q <= 16'h0000;
		end else begin
			gap_q <= gap_d;
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// request level at the strobe was held since the previous strobe
	assign take_request = req_s_q && insertable;
	always @* begin
		strobe_d = fire;
		mark_d = fire && (cnt_q == 6'h00);
		valid_d = ovh_slot_strobe;
		index_d = ovh_slot_index;
		bit_d = ovh_bit_out;
		inserted_d = ovh_bit_inserted;
		if (fire) begin
			index_d = cnt_q;
		end
		if (ovh_slot_strobe) begin
			if (ovh_slot_index[0]) begin
				bit_d = framing_bit;
				inserted_d = 1'b0;
			end else if (take_request) begin
				bit_d = val_s_q;
				inserted_d = 1'b1;
			end else begin
				// refused or not requested: internal bit
				bit_d = internal_value;
				inserted_d = 1'b0;
			end
		end
	end
	// every port leaves straight from its own flip-flop
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovh_slot_strobe <= 1'b0;
		end else begin
			ovh_slot_strobe <= strobe_d;
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovh_frame_mark <= 1'b0;
		end else begin
			ovh_frame_mark <= mark_d;
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovh_bit_valid <= 1'b0;
		end else begin
			ovh_bit_valid <= valid_d;
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovh_slot_index <= 6'h00;
		end else begin
			ovh_slot_index <= index_d;
		end
	end
	// bit and its origin hold until the next slot is processed
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovh_bit_out <= 1'b0;
		end else begin
			ovh_bit_out <= bit_d;
		end
	end
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovh_bit_inserted <= 1'b0;
		end else begin
			ovh_bit_inserted <= inserted_d;
		end
	end
endmodule
`default_nettype wire

/* File: design/dsoi_slot_map.v */
// slot classification: insertable flag and framing bit value per count
`timescale 1ns/100ps
`default_nettype none
`include "dsoi_consts.vh"
module dsoi_slot_map (
	input wire [5:0] slot_cnt,
	output reg insertable,
	output reg framing_bit
);
	reg [3:0] pat;
	always @* begin
		pat = `DSOI_FRAMING_PATTERN;
		insertable = 1'b0;
		framing_bit = 1'b0;
		if (slot_cnt[0]) begin
			// odd counts: F1 F0 F0 F1 repeating every eight
			framing_bit = pat[slot_cnt[2:1]];
		end else if (slot_cnt == `DSOI_SLOT_P0 || slot_cnt == `DSOI_SLOT_P1 ||
			slot_cnt == `DSOI_SLOT_M0) begin
			insertable = 1'b0;
		end else begin
			insertable = 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verif/dsoi_chk_sva.sv */
// overhead port assertions
`timescale 1ns/100ps
`default_nettype none
module dsoi_chk (
	input wire clk_sys,
	input wire rstn,
	input wire ovh_slot_strobe,
	input wire ovh_frame_mark,
	input wire ovh_bit_valid,
	input wire ovh_bit_out,
	input wire ovh_bit_inserted,
	input wire [5:0] ovh_slot_index
);
	wire s = ovh_slot_strobe;
	wire [5:0] i = ovh_slot_index;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_gap; (!s)[*7] ##1 s; endsequence
	property p_slot; s |=> !s && ovh_bit_valid ##1 s_gap; endproperty
	a_slot: assert property (p_slot) else $error("slot timing");
	property p_mark; ovh_frame_mark || s |-> ovh_frame_mark == (s && i == 6'h00); endproperty
	a_mark: assert property (p_mark) else $error("frame mark");
	property p_ref; ovh_bit_valid && (i[0] || i == 6'h10 || i == 6'h18 || i == 6'h20)
		|-> !ovh_bit_inserted; endproperty
	a_ref: assert property (p_ref) else $error("refused slot");
	property p_valid; ovh_bit_valid |-> $past(s); endproperty
	a_valid: assert property (p_valid) else $error("valid without strobe");
	property p_hold; s |=> $stable(i) [*8]; endproperty
	a_hold: assert property (p_hold) else $error("slot index moved");
	property p_bit; !ovh_bit_valid |-> $stable(ovh_bit_out) && $stable(ovh_bit_inserted);
	endproperty
	a_bit: assert property (p_bit) else $error("bit moved between slots");
	sequence s_last; s && i == 6'h25 ##1 !s; endsequence
	property p_wrap; s_last ##1 s_gap |-> ovh_frame_mark; endproperty
	a_wrap: assert property (p_wrap) else $error("frame did not restart");
endmodule
bind dsoi_port dsoi_chk dsoi_chk_i (.*);
`default_nettype wire

/* File: verif/dsoi_term.sv */
// terminal model
`timescale 1ns/100ps
`default_nettype none
module dsoi_term (
	input wire clk_sys,
	input wire ovh_slot_strobe,
	output var logic ovh_insert_request = 1'h0,
	output var logic ovh_insert_value = 1'h0
);
	always @(negedge clk_sys) if (ovh_slot_strobe) begin
		ovh_insert_request <= 1'($urandom);
		ovh_insert_value <= 1'($urandom);
	end
endmodule
`default_nettype wire

/* File: verif/tb_dsoi_port.sv */
// overhead port bench
`timescale 1ns/100ps
`default_nettype none
module tb_dsoi_port;
	logic clk_sys = 1'h0, rstn = 1'h0, internal_value = 1'h0, ok;
	logic ovh_insert_request, ovh_insert_value, ovh_slot_strobe, ovh_frame_mark;
	logic ovh_bit_valid, ovh_bit_out, ovh_bit_inserted;
	logic [5:0] ovh_slot_index, k = 6'h25;
	logic [7:0] q[$];
	int num_errors = 0, num_checks = 0, n;
	dsoi_port #(.SPACING(16'h0008)) dsoi_port_i (.*);
	dsoi_term dsoi_term_i (.*);
	initial forever #5 clk_sys = ~clk_sys;
	task check(input logic [7:0] seen, want);
		num_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("FAIL %0t slot %h", $time, want);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(negedge clk_sys) begin
		if (ovh_bit_valid) internal_value <= 1'($urandom);
		if (ovh_slot_strobe) begin
			k = k == 6'h25 ? 6'h00 : k + 6'h01;
			ok = ovh_insert_request && !k[0] && k != 6'h10 && k != 6'h18 && k != 6'h20;
			q.push_back({ok, ok ? ovh_insert_value : k[0] ? k[2] == k[1] : internal_value, k});
		end
	end
	always @(negedge clk_sys) if (ovh_bit_valid)
		check({ovh_bit_inserted, ovh_bit_out, ovh_slot_index}, q.pop_front());
	initial begin
		void'($urandom(32'hEC96));
		repeat (2) @(negedge clk_sys);
		rstn = 1'h1;
		for (n = 0; n < 1200 && num_checks < 114; n++) @(negedge clk_sys);
		if (n == 1200) num_errors++;
		$display("three frames done");
		give_verdict();
	end
endmodule
`default_nettype wire
